/* design/capture_compare_unit.sv */
// capture/compare unit: capture of timer on pin edges, compare with output latch
// assumes timers count in this clock domain and pins sampled synchronously
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module capture_compare_unit (
  // clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               reset_i,
  // register port
  input  wire ccu_pkg::reg_req_t  req_i,
  output logic [7:0]              rdata_o,
  // timers
  input  wire ccu_pkg::timers_t   timers_i,
  output logic [2:0]              timer_clear_o,
  // capture sources (index 0 is the pin itself)
  input  wire logic [3:0]         cap_src_i,
  // pin
  input  wire logic               pin_in_i,
  output logic                    pin_out_o,
  output logic                    pin_oe_o,
  // internal outputs
  output logic                    cmp_out_o,
  output logic                    irq_o
);
  logic [7:0]  ctrl_ff;
  logic [7:0]  caps_ff;
  logic [15:0] value_ff;
  logic        flag_ff;
  logic        dir_in_ff;
  logic        port_lat_ff;
  logic        cmp_lat_ff;
  logic        pulse_ff;
  logic [3:0]  presc_ff;
  logic        sync1_ff;
  logic        sync2_ff;
  logic        prev_ff;
  logic [7:0]  rdata_ff;

  logic [3:0]  mode;
  logic        en;
  logic        is_cap;
  logic        is_cmp;
  logic [1:0]  tsel;
  logic [15:0] tcount;
  logic        src;
  logic        rise;
  logic        fall;
  logic        edge_hit;
  logic        cap_evt;
  logic        match;
  logic        match_ff;
  logic        cmp_evt;
  logic        nxt_flag;

  assign mode   = ctrl_ff[3:0];
  assign en     = ctrl_ff[ccu_pkg::CTRL_EN_BIT];
  assign is_cap = en && (mode >= ccu_pkg::MODE_CAP_ANY) && (mode <= ccu_pkg::MODE_CAP_R16);
  assign is_cmp = en && (mode != ccu_pkg::MODE_OFF) && !is_cap;
  assign tsel   = caps_ff[ccu_pkg::TSEL_LSB +: 2];

  // only odd timers serve this unit; select code 3 parks on none
  always_comb begin
    case (tsel)
      2'h0:    tcount = timers_i.t1;
      2'h1:    tcount = timers_i.t3;
      2'h2:    tcount = timers_i.t5;
      default: tcount = 16'h0000;
    endcase
  end

  // pin is looped back so its own drive is sensed as well
  always_comb begin
    case (caps_ff[ccu_pkg::CAPS_SRC_LSB +: 2])
      2'h0:    src = sync2_ff;
      2'h1:    src = cap_src_i[1];
      2'h2:    src = cap_src_i[2];
      default: src = cap_src_i[3];
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff  <= 1'b0;
    end else begin
      sync1_ff <= pin_out_o & pin_oe_o | pin_in_i & !pin_oe_o;
      sync2_ff <= sync1_ff;
      prev_ff  <= src;
    end
  end

  assign rise = src && !prev_ff;
  assign fall = !src && prev_ff;

  always_comb begin
    case (mode)
      ccu_pkg::MODE_CAP_ANY:  edge_hit = rise | fall;
      ccu_pkg::MODE_CAP_FALL: edge_hit = fall;
      default:                edge_hit = rise;
    endcase
  end

  // prescaler survives a direct mode change between capture settings
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      presc_ff <= 4'h0;
    end else if (!is_cap) begin
      presc_ff <= 4'h0;
    end else if (edge_hit && (mode == ccu_pkg::MODE_CAP_R4 || mode == ccu_pkg::MODE_CAP_R16)) begin
      presc_ff <= (cap_evt) ? 4'h0 : presc_ff + 4'h1;
    end
  end

  always_comb begin
    case (mode)
      ccu_pkg::MODE_CAP_R4:  cap_evt = is_cap && edge_hit && presc_ff >= ccu_pkg::PRESC_4;
      ccu_pkg::MODE_CAP_R16: cap_evt = is_cap && edge_hit && presc_ff >= ccu_pkg::PRESC_16;
      default:               cap_evt = is_cap && edge_hit;
    endcase
  end

  // compare fires once on entry to equality, not on every held cycle
  assign match   = is_cmp && (tsel != ccu_pkg::TSEL_NONE) && (tcount == value_ff);
  assign cmp_evt = match && !match_ff;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      match_ff <= 1'b0;
    end else begin
      match_ff <= match;
    end
  end

  // control, source select and pin direction registers
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_ff     <= ccu_pkg::CTRL_RESET;
      caps_ff     <= ccu_pkg::BYTE_ZERO;
      dir_in_ff   <= 1'b1;
      port_lat_ff <= 1'b0;
    end else if (req_i.wr) begin
      case (req_i.addr)
        ccu_pkg::ADDR_CTRL: ctrl_ff <= req_i.wdata;
        ccu_pkg::ADDR_CAPS: caps_ff <= req_i.wdata;
        ccu_pkg::ADDR_PIN: begin
          dir_in_ff   <= req_i.wdata[ccu_pkg::PIN_DIR_BIT];
          port_lat_ff <= req_i.wdata[ccu_pkg::PIN_LAT_BIT];
        end
        default: ;
      endcase
    end
  end

  // value bytes: hardware capture wins over a software write
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      value_ff <= 16'h0000;
    end else if (cap_evt) begin
      value_ff <= tcount;
    end else if (req_i.wr && req_i.addr == ccu_pkg::ADDR_VLOW) begin
      value_ff[7:0] <= req_i.wdata;
    end else if (req_i.wr && req_i.addr == ccu_pkg::ADDR_VHIGH) begin
      value_ff[15:8] <= req_i.wdata;
    end
  end

  // sticky flag, set wins over the software clear
  always_comb begin
    nxt_flag = flag_ff;
    if (req_i.wr && req_i.addr == ccu_pkg::ADDR_FLAG && !req_i.wdata[0]) begin
      nxt_flag = 1'b0;
    end
    if (cap_evt || cmp_evt) begin
      nxt_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  // compare output latch; a zero control write forces it low
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cmp_lat_ff <= 1'b0;
      pulse_ff   <= 1'b0;
    end else if (req_i.wr && req_i.addr == ccu_pkg::ADDR_CTRL && req_i.wdata == ccu_pkg::BYTE_ZERO) begin
      cmp_lat_ff <= 1'b0;
      pulse_ff   <= 1'b0;
    end else begin
      pulse_ff <= 1'b0;
      if (cmp_evt) begin
        case (mode)
          ccu_pkg::MODE_TOGCLR:   cmp_lat_ff <= !cmp_lat_ff;
          ccu_pkg::MODE_TOG:      cmp_lat_ff <= !cmp_lat_ff;
          ccu_pkg::MODE_SET:      cmp_lat_ff <= 1'b1;
          ccu_pkg::MODE_CLR:      cmp_lat_ff <= 1'b0;
          ccu_pkg::MODE_PULSE:    pulse_ff   <= 1'b1;
          ccu_pkg::MODE_PULSECLR: pulse_ff   <= 1'b1;
          default:                cmp_lat_ff <= cmp_lat_ff;
        endcase
      end
    end
  end

  always_comb begin
    timer_clear_o = 3'b000;
    if (cmp_evt && (mode == ccu_pkg::MODE_TOGCLR || mode == ccu_pkg::MODE_PULSECLR)) begin
      case (tsel)
        2'h0:    timer_clear_o = 3'b001;
        2'h1:    timer_clear_o = 3'b010;
        2'h2:    timer_clear_o = 3'b100;
        default: timer_clear_o = 3'b000;
      endcase
    end
  end

  // internal compare output, also the wake source via the flag
  assign cmp_out_o = cmp_lat_ff | pulse_ff;
  assign irq_o     = flag_ff;

  // open drain drives only the low level
  always_comb begin
    pin_out_o = is_cmp ? cmp_out_o : port_lat_ff;
    pin_oe_o  = !dir_in_ff;
    if (is_cmp && ctrl_ff[ccu_pkg::CTRL_OD_BIT]) begin
      pin_out_o = 1'b0;
      pin_oe_o  = !dir_in_ff && !cmp_out_o;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_ff <= ccu_pkg::BYTE_ZERO;
    end else if (req_i.rd) begin
      case (req_i.addr)
        ccu_pkg::ADDR_CTRL: begin
          rdata_ff <= ctrl_ff;
          rdata_ff[ccu_pkg::CTRL_OUT_BIT] <= cmp_out_o;
        end
        ccu_pkg::ADDR_CAPS:  rdata_ff <= caps_ff;
        ccu_pkg::ADDR_VLOW:  rdata_ff <= value_ff[7:0];
        ccu_pkg::ADDR_VHIGH: rdata_ff <= value_ff[15:8];
        ccu_pkg::ADDR_FLAG:  rdata_ff <= {7'h00, flag_ff};
        ccu_pkg::ADDR_PIN:   rdata_ff <= {6'h00, port_lat_ff, dir_in_ff};
        default:             rdata_ff <= ccu_pkg::BYTE_ZERO;
      endcase
    end else begin
      rdata_ff <= ccu_pkg::BYTE_ZERO;
    end
  end
  assign rdata_o = rdata_ff;

  cap_sets_flag_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    cap_evt |=> flag_ff) else $error("capture did not set flag");
  cap_loads_val_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    cap_evt |=> value_ff == $past(tcount)) else $error("capture value wrong");
  presc_off_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !is_cap |=> presc_ff == 4'h0) else $error("prescaler not cleared");
  zero_ctrl_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (req_i.wr && req_i.addr == ccu_pkg::ADDR_CTRL && req_i.wdata == ccu_pkg::BYTE_ZERO)
    |=> !cmp_out_o) else $error("latch not low");
  cmp_flag_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    cmp_evt |=> flag_ff) else $error("match did not set flag");
  timer_clr_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (cmp_evt && mode == ccu_pkg::MODE_TOG) |-> timer_clear_o == 3'b000)
    else $error("toggle mode cleared timer");
  set_mode_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (cmp_evt && mode == ccu_pkg::MODE_SET && !req_i.wr) |=> cmp_lat_ff)
    else $error("set mode failed");
  flag_sticky_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (flag_ff && !(req_i.wr && req_i.addr == ccu_pkg::ADDR_FLAG)) |=> flag_ff)
    else $error("flag cleared by hardware");
  pulse_len_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    pulse_ff |=> !pulse_ff) else $error("pulse longer than one cycle");
  tclr_match_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (cmp_evt && mode == ccu_pkg::MODE_TOGCLR && tsel == 2'h0) |-> timer_clear_o == 3'b001)
    else $error("toggle-clear did not clear timer");
  od_high_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (is_cmp && ctrl_ff[ccu_pkg::CTRL_OD_BIT] && cmp_out_o) |-> !pin_oe_o)
    else $error("open drain drove high level");
endmodule

/* shared/ccu_pkg.sv */
// capture/compare unit constants, register map and field layouts
// assumes a plain strobe register port and timers supplied from outside
// Summary of operation
// - value is two separately addressable bytes, low and high
// - capture/compare picks one of three odd timers; PWM group is outside
// - pin driver can run open-drain in compare mode
// - capture copies full 16-bit timer count into value
// - mode picks falling, rising, 4th rising, 16th rising or any edge
// - capture sets sticky interrupt flag; only software clears it
// - newer capture overwrites older value, no overflow record
// - separate capture source select register picks input
// - capture senses pin itself, so own port writes can capture
// - prescaler counter cleared when off, not capture, or reset
// - prescaler change keeps counter; software writes zero first
// - capture works in sleep with external timer clock
// - compare matches value against timer count continuously
// - match actions: toggle+clear, toggle, set, clear, pulse, pulse+clear
// - modes 0001 and 1011 clear the selected timer on match
// - every compare mode raises interrupt flag on match
// - writing zero to control forces compare latch low, port latch kept
// - compare output offered internally to other peripherals
// - compare in sleep needs running timer; match wakes device
// - reset restores registers and makes pin an input
package ccu_pkg;
  localparam logic [2:0] ADDR_CTRL  = 3'h0;
  localparam logic [2:0] ADDR_CAPS  = 3'h1;
  localparam logic [2:0] ADDR_VLOW  = 3'h2;
  localparam logic [2:0] ADDR_VHIGH = 3'h3;
  localparam logic [2:0] ADDR_FLAG  = 3'h4;
  localparam logic [2:0] ADDR_PIN   = 3'h5;

  localparam int CTRL_EN_BIT  = 7;
  localparam int CTRL_OUT_BIT = 5;
  localparam int CTRL_OD_BIT  = 4;
  localparam int PIN_DIR_BIT  = 0;
  localparam int PIN_LAT_BIT  = 1;
  localparam int CAPS_SRC_LSB = 0;
  localparam int TSEL_LSB     = 4;

  localparam logic [3:0] MODE_OFF      = 4'h0;
  localparam logic [3:0] MODE_TOGCLR   = 4'h1;
  localparam logic [3:0] MODE_TOG      = 4'h2;
  localparam logic [3:0] MODE_CAP_ANY  = 4'h3;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_R4   = 4'h6;
  localparam logic [3:0] MODE_CAP_R16  = 4'h7;
  localparam logic [3:0] MODE_SET      = 4'h8;
  localparam logic [3:0] MODE_CLR      = 4'h9;
  localparam logic [3:0] MODE_PULSE    = 4'hA;
  localparam logic [3:0] MODE_PULSECLR = 4'hB;

  localparam logic [3:0] PRESC_4  = 4'h3;
  localparam logic [3:0] PRESC_16 = 4'hF;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  localparam logic [1:0] TSEL_NONE  = 2'h3;

  typedef struct packed {
    logic [15:0] t1;
    logic [15:0] t3;
    logic [15:0] t5;
  } timers_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

/* verif/ccu_far_side.sv */
// far-side model: the three shared timers and the resolved pin wire
// assumes the bench steers timer run and the outside pin level
`timescale 1ns/1ps
module ccu_far_side (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  // bench control
  input  wire logic       run_i,
  input  wire logic       ext_level_i,
  // unit side
  input  wire logic [2:0] timer_clear_i,
  input  wire logic       pin_out_i,
  input  wire logic       pin_oe_i,
  output ccu_pkg::timers_t timers_o,
  output logic            pin_level_o
);
  logic [1:0] div_ff;
  logic       step;

  // timers step on the instruction clock, never on every system clock
  assign step = run_i && (div_ff == 2'h3);
  // unit senses its own driven level, so port writes can capture
  assign pin_level_o = pin_oe_i ? pin_out_i : ext_level_i;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      div_ff   <= 2'h0;
      timers_o <= '0;
    end else begin
      if (run_i) div_ff <= div_ff + 2'h1;
      if (timer_clear_i[0]) timers_o.t1 <= 16'h0000;
      else if (step) timers_o.t1 <= timers_o.t1 + 16'h0001;
      if (timer_clear_i[1]) timers_o.t3 <= 16'h0000;
      else if (step) timers_o.t3 <= timers_o.t3 + 16'h0001;
      if (timer_clear_i[2]) timers_o.t5 <= 16'h0000;
      else if (step) timers_o.t5 <= timers_o.t5 + 16'h0001;
    end
  end
endmodule

/* verif/tb_capture_compare_unit.sv */
// bench for the capture/compare unit: capture modes, compare actions
// assumes the far-side model supplies timers and the resolved pin
`timescale 1ns/1ps
module tb_capture_compare_unit;
  logic              clk_sys_i;
  logic              reset_i;
  ccu_pkg::reg_req_t req;
  ccu_pkg::timers_t  timers;
  logic [7:0]        rdata, lo, hi;
  logic [2:0]        tclr;
  logic              pin_lvl, pin_out, pin_oe, cmp_out, irq;
  logic              run, ext, hi_seen, clr_seen;
  logic [15:0]       tv;
  int                num_errors, cmp_count, n;
  logic [3:0]        cm [5] = '{ccu_pkg::MODE_CAP_FALL, ccu_pkg::MODE_CAP_RISE,
    ccu_pkg::MODE_CAP_ANY, ccu_pkg::MODE_CAP_R4, ccu_pkg::MODE_CAP_R16};
  logic [3:0]        om [6] = '{ccu_pkg::MODE_SET, ccu_pkg::MODE_CLR, ccu_pkg::MODE_TOG,
    ccu_pkg::MODE_TOGCLR, ccu_pkg::MODE_PULSE, ccu_pkg::MODE_PULSECLR};
  // final output, output high seen, timer cleared
  logic [2:0]        oe_x [6] = '{3'h6, 3'h0, 3'h6, 3'h7, 3'h2, 3'h3};

  capture_compare_unit i_capture_compare_unit (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .req_i(req), .rdata_o(rdata),
    .timers_i(timers), .timer_clear_o(tclr), .cap_src_i(4'h0), .pin_in_i(pin_lvl),
    .pin_out_o(pin_out), .pin_oe_o(pin_oe), .cmp_out_o(cmp_out), .irq_o(irq));
  ccu_far_side i_ccu_far_side (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .run_i(run), .ext_level_i(ext),
    .timer_clear_i(tclr), .pin_out_i(pin_out), .pin_oe_i(pin_oe),
    .timers_o(timers), .pin_level_o(pin_lvl));

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d, compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys_i);
    req.wr <= 1'b0;
    // let the write settle before anyone looks at outputs
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys_i);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  // five cycles cover the two-stage sync plus the capture register
  task automatic pin(input logic v);
    @(posedge clk_sys_i);
    ext <= v;
    repeat (5) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic step(input int c);
    @(posedge clk_sys_i);
    run <= 1'b1;
    repeat (c) @(posedge clk_sys_i);
    run <= 1'b0;
    #1;
  endtask

  function automatic int first_pulse(input logic [3:0] m);
    return (m == ccu_pkg::MODE_CAP_R4) ? 4 : (m == ccu_pkg::MODE_CAP_R16) ? 16 : 1;
  endfunction

  initial begin
    repeat (100000) @(posedge clk_sys_i);
    num_errors++;
    finish_test();
  end

  initial begin
    reset_i = 1'b1;
    req = '0;
    run = 1'b0;
    ext = 1'b0;
    void'($urandom(68));
    repeat (8) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    chk("pin enable at reset", pin_oe, 1'b0);
    rd(ccu_pkg::ADDR_CTRL, lo);
    chk("control at reset", lo, ccu_pkg::CTRL_RESET);
    rd(ccu_pkg::ADDR_PIN, lo);
    chk("pin direction at reset", lo[ccu_pkg::PIN_DIR_BIT], 1'b1);
    rd(3'h7, lo);
    chk("unmapped read", lo, 8'h00);
    wr(ccu_pkg::ADDR_CAPS, 8'h00);
    foreach (cm[i]) begin
      wr(ccu_pkg::ADDR_CTRL, ccu_pkg::CTRL_RESET);
      wr(ccu_pkg::ADDR_CTRL, 8'h80 | 8'(cm[i]));
      wr(ccu_pkg::ADDR_FLAG, ccu_pkg::BYTE_ZERO);
      for (int k = 1; k <= 16; k++) begin
        step(4 + $urandom_range(20));
        tv = timers.t1;
        pin(1'b1);
        // flag is sticky, so a falling-edge capture still shows on later rises
        chk("flag after rise", irq,
          1'(k >= first_pulse(cm[i]) + int'(cm[i] == ccu_pkg::MODE_CAP_FALL)));
        pin(1'b0);
        chk("flag after fall", irq, 1'(k >= first_pulse(cm[i])));
      end
      rd(ccu_pkg::ADDR_VLOW, lo);
      rd(ccu_pkg::ADDR_VHIGH, hi);
      chk("captured value", {hi, lo}, tv);
    end
    foreach (om[i]) begin
      wr(ccu_pkg::ADDR_CTRL, ccu_pkg::CTRL_RESET);
      wr(ccu_pkg::ADDR_FLAG, ccu_pkg::BYTE_ZERO);
      chk("latch after control cleared", cmp_out, 1'b0);
      chk("flag after software clear", irq, 1'b0);
      tv = timers.t1 + 16'(3 + $urandom_range(30));
      wr(ccu_pkg::ADDR_VLOW, tv[7:0]);
      wr(ccu_pkg::ADDR_VHIGH, tv[15:8]);
      rd(ccu_pkg::ADDR_VLOW, lo);
      rd(ccu_pkg::ADDR_VHIGH, hi);
      chk("value readback", {hi, lo}, tv);
      wr(ccu_pkg::ADDR_CTRL, 8'h80 | 8'(om[i]));
      hi_seen = 1'b0;
      clr_seen = 1'b0;
      @(posedge clk_sys_i);
      run <= 1'b1;
      for (n = 0; n < 400 && irq !== 1'b1; n++) begin
        @(posedge clk_sys_i);
        #1;
        hi_seen = hi_seen | cmp_out;
        clr_seen = clr_seen | tclr[0];
      end
      chk("flag on match", irq, 1'b1);
      repeat (3) @(posedge clk_sys_i);
      run <= 1'b0;
      #1;
      chk("compare action", {cmp_out, hi_seen, clr_seen}, oe_x[i]);
    end
    finish_test();
  end
endmodule
